/* File: rtl/emac_tx_rx.sv */
/*
 * mac transmit engine with its data fifo, and receive preamble hunter.
 * assumes synchronous inputs, a host filling the fifo byte by byte,
 * and a phy taking one byte per eight bit times.
 */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - start at threshold or whole frame buffered
// - add preamble, delimiter, then frame check
// - pad short data to 60 bytes
// - first preamble byte becomes start pair
// - end pair right after last check byte
// - send only after 96 idle bits, backoff
// - carrier in first 60 bits restarts gap
// - last 36 gap bits ignore carrier
// - collision: stop data, jam, then backoff
// - collision in preamble finishes preamble first
// - random backoff slots, exponent capped at ten
// - sixteen collided attempts flag excessive collisions
// - underflow flags status, ends with bad crc
// - jabber timer cuts transmission, flags status
// - collision after 64 bytes aborts, no retry
// - host memory error ends frame flagged
// - status per frame, interrupt when enabled
// - watch medium, start preamble on activity
// - minimum preamble 8, 16 or 20 bits
// - ten-mode skips 8 bits, seeks delimiter
// - 00 or early 11 aborts, await idle
// - fast mode needs start pair, else abort

// -------------------------------------------------
// data fifo
// -------------------------------------------------
module emac_fifo #(
  parameter int W = 9,
  parameter int D = 32
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [W-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [W-1:0] o_rd_data,
  output logic [$clog2(D):0] o_count
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic wr, rd;
  assign wr = i_wr_valid && o_wr_ready;
  assign rd = i_rd_ready && o_rd_valid;
  assign o_rd_valid = cnt_r != '0;
  assign o_wr_ready = cnt_r != (AW+1)'(D);
  assign o_rd_data = mem[rp_r];
  assign o_count = cnt_r;
  // pointers and fill level
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (wr) wp_r <= wp_r + 1'b1;
      if (rd) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
  // storage
  always_ff @(posedge i_clk) begin
    if (wr) mem[wp_r] <= i_wr_data;
  end
endmodule

// -------------------------------------------------
// top: transmit engine and receive preamble hunter
// -------------------------------------------------
module emac_tx_rx (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_speed_100,
  input wire logic i_sym_mode,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_last,
  output logic o_tx_ready,
  input wire logic [5:0] i_tx_thresh,
  input wire logic i_pad_en,
  input wire logic i_jab_long,
  input wire logic i_host_err,
  input wire logic i_int_en,
  input wire logic i_under_clr,
  input wire logic i_crs,
  input wire logic i_col,
  output logic [7:0] o_txd,
  output logic [1:0] o_tx_sym,
  output logic o_tx_en,
  output logic o_tx_done,
  output logic [5:0] o_tx_status,
  output logic [3:0] o_col_count,
  output logic o_tx_int,
  output logic o_under_sticky,
  input wire logic i_rx_en,
  input wire logic i_rx_act,
  input wire logic [1:0] i_rx_mode,
  input wire logic i_snooze,
  input wire logic i_rx_bit_en,
  input wire logic i_rx_bit,
  input wire logic i_rx_jk,
  output logic o_rx_sfd,
  output logic o_rx_abort,
  output logic o_rx_frame
);
  typedef enum logic [2:0] {T_IDLE, T_PRE, T_DATA, T_FCS, T_EOS, T_JAM, T_FLUSH, T_DONE} emac_tx_e;
  typedef enum logic [1:0] {R_IDLE, R_HUNT, R_FRAME, R_WAIT} emac_rx_e;

  // crc-32 over one byte, reflected form
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ emac_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  emac_tx_e st_r;
  emac_rx_e rs_r;
  logic [4:0] bcyc_r;
  logic [2:0] bbit_r;
  logic bit_tick, byte_tick;
  logic [6:0] gap_r;
  logic [18:0] bo_r;
  logic [14:0] jab_r;
  logic [15:0] lfsr_r;
  logic [5:0] lasts_r;
  logic f_valid, f_pop;
  logic [8:0] f_data;
  logic [5:0] f_count;
  logic [2:0] pcnt_r;
  logic [10:0] nb_r;
  logic [31:0] crc_r, crc_nx, fcs_r;
  logic col_r, mem_r, last_r, pad_r, m100_r, retry_r;
  logic [4:0] att_r;
  logic [5:0] stat_r;
  logic in_body, jab_hit, cut, start;
  logic [9:0] bo_mask;

  // -------------------------------------------------
  // bit and byte time base
  // -------------------------------------------------
  // one bit tick per medium bit time, byte tick every eighth
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bcyc_r <= '0;
      bbit_r <= '0;
    end else if (bit_tick) begin
      bcyc_r <= '0;
      bbit_r <= bbit_r + 1'b1;
    end else begin
      bcyc_r <= bcyc_r + 1'b1;
    end
  end
  assign bit_tick = bcyc_r == ((i_speed_100 ? emac_pkg::BIT_CYC_100 : emac_pkg::BIT_CYC_10) - 5'd1);
  assign byte_tick = bit_tick && bbit_r == 3'd7;

  // -------------------------------------------------
  // fifo and frame bookkeeping
  // -------------------------------------------------
  emac_fifo #(.W(emac_pkg::FIFO_W), .D(emac_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_wr_valid(i_tx_valid && o_tx_ready),
    .o_wr_ready(),
    .i_wr_data({i_tx_last, i_tx_data}),
    .o_rd_valid(f_valid),
    .i_rd_ready(f_pop),
    .o_rd_data(f_data),
    .o_count(f_count)
  );
  // registered ready: fifo count after this cycle below depth minus one, one entry kept spare
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tx_ready <= 1'b0;
      lasts_r <= '0;
    end else begin
      o_tx_ready <= (f_count + 6'(o_tx_ready && i_tx_valid) - 6'(f_pop))
                    < 6'(emac_pkg::FIFO_DEPTH - 1);
      lasts_r <= lasts_r + 6'(o_tx_ready && i_tx_valid && i_tx_last)
                 - 6'(f_pop && f_data[8]);
    end
  end

  // -------------------------------------------------
  // deferral, backoff, jabber and random source
  // -------------------------------------------------
  // gap restarts on carrier only in the first phase
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gap_r <= '0;
    end else if (o_tx_en) begin
      gap_r <= '0;
    end else if (i_crs && gap_r < emac_pkg::GAP_PH1_BITS) begin
      gap_r <= '0;
    end else if (bit_tick && gap_r < emac_pkg::GAP_ALL_BITS) begin
      gap_r <= gap_r + 1'b1;
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lfsr_r <= 16'hACE1;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end
  // r below two to the k, k capped at the backoff limit
  assign bo_mask = 10'((11'd1 << ((att_r < emac_pkg::BACKOFF_LIMIT) ? att_r
                   : emac_pkg::BACKOFF_LIMIT)) - 11'd1);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bo_r <= '0;
    end else if (st_r == T_DONE && retry_r) begin
      bo_r <= {lfsr_r[9:0] & bo_mask, 9'h000};
    end else if (bit_tick && bo_r != '0) begin
      bo_r <= bo_r - 1'b1;
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      jab_r <= '0;
    end else if (!o_tx_en) begin
      jab_r <= '0;
    end else if (bit_tick && !jab_hit) begin
      jab_r <= jab_r + 1'b1;
    end
  end
  assign jab_hit = jab_r >= (i_jab_long ? emac_pkg::JAB_LONG_BITS : emac_pkg::JAB_SHORT_BITS);

  // -------------------------------------------------
  // transmit state machine
  // -------------------------------------------------
  assign in_body = st_r == T_DATA && !last_r;
  assign cut = jab_hit || col_r || mem_r;
  assign f_pop = (byte_tick && in_body && !cut && f_valid) || (st_r == T_FLUSH && f_valid);
  assign start = st_r == T_IDLE && byte_tick && gap_r == emac_pkg::GAP_ALL_BITS && bo_r == '0
                 && (f_count >= i_tx_thresh || lasts_r != '0);
  assign crc_nx = crc_byte(crc_r, last_r ? emac_pkg::PAD_BYTE : f_data[7:0]);

  // collision and host error are latched until the engine returns to idle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      col_r <= 1'b0;
      mem_r <= 1'b0;
    end else if (st_r == T_IDLE) begin
      col_r <= 1'b0;
      mem_r <= 1'b0;
    end else begin
      col_r <= col_r || (i_col && o_tx_en && st_r != T_JAM);
      mem_r <= mem_r || (i_host_err && o_tx_en);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= T_IDLE;
      o_tx_en <= 1'b0;
      o_txd <= '0;
      o_tx_sym <= emac_pkg::SYM_DATA;
      pcnt_r <= '0;
      nb_r <= '0;
      crc_r <= emac_pkg::CRC_INIT;
      fcs_r <= '0;
      last_r <= 1'b0;
      pad_r <= 1'b0;
      m100_r <= 1'b0;
      retry_r <= 1'b0;
      att_r <= '0;
      stat_r <= '0;
      o_tx_done <= 1'b0;
      o_tx_status <= '0;
      o_col_count <= '0;
    end else begin
      o_tx_done <= 1'b0;
      unique case (st_r)
        T_IDLE: if (start) begin
          st_r <= T_PRE;
          o_tx_en <= 1'b1;
          o_txd <= emac_pkg::PRE_BYTE;
          o_tx_sym <= (i_speed_100 && i_sym_mode) ? emac_pkg::SYM_JK : emac_pkg::SYM_DATA;
          m100_r <= i_speed_100 && i_sym_mode;
          pcnt_r <= 3'd1;
          nb_r <= '0;
          crc_r <= emac_pkg::CRC_INIT;
          last_r <= 1'b0;
          pad_r <= i_pad_en;
          retry_r <= 1'b0;
          stat_r <= '0;
        end
        // preamble runs to the end even under collision
        T_PRE: if (byte_tick) begin
          o_tx_sym <= emac_pkg::SYM_DATA;
          pcnt_r <= pcnt_r + 1'b1;
          if (pcnt_r == emac_pkg::PRE_BYTES) begin
            st_r <= T_DATA;
            o_txd <= emac_pkg::SFD_BYTE;
          end else begin
            o_txd <= emac_pkg::PRE_BYTE;
          end
        end
        T_DATA, T_FCS: if (byte_tick) begin
          if (jab_hit) begin
            o_tx_en <= 1'b0;
            stat_r[emac_pkg::ST_JAB] <= 1'b1;
            st_r <= last_r ? T_DONE : T_FLUSH;
          end else if (col_r && nb_r >= emac_pkg::LATE_COL_BYTES) begin
            o_tx_en <= 1'b0;
            stat_r[emac_pkg::ST_LATE] <= 1'b1;
            st_r <= last_r ? T_DONE : T_FLUSH;
          end else if (col_r) begin
            st_r <= T_JAM;
            o_txd <= emac_pkg::JAM_BYTE;
            pcnt_r <= 3'd1;
          end else if (mem_r) begin
            o_tx_en <= 1'b0;
            stat_r[emac_pkg::ST_MEM] <= 1'b1;
            st_r <= last_r ? T_DONE : T_FLUSH;
          end else if (st_r == T_FCS) begin
            o_txd <= fcs_r[7:0];
            fcs_r <= fcs_r >> 8;
            nb_r <= nb_r + 1'b1;
            pcnt_r <= pcnt_r + 1'b1;
            if (pcnt_r == 3'd4) begin
              nb_r <= nb_r;
              o_tx_sym <= m100_r ? emac_pkg::SYM_TR : emac_pkg::SYM_DATA;
              o_tx_en <= m100_r;
              st_r <= m100_r ? T_EOS : T_DONE;
            end
          end else if (last_r && pad_r && nb_r < emac_pkg::MIN_BODY_BYTES) begin
            o_txd <= emac_pkg::PAD_BYTE;
            crc_r <= crc_nx;
            nb_r <= nb_r + 1'b1;
          end else if (last_r || !f_valid) begin
            // underflow leaves the crc uninverted so the frame checks bad
            stat_r[emac_pkg::ST_UNDER] <= !last_r;
            o_txd <= last_r ? ~crc_r[7:0] : crc_r[7:0];
            fcs_r <= last_r ? ~crc_r : crc_r;
            fcs_r[23:0] <= last_r ? ~crc_r[31:8] : crc_r[31:8];
            nb_r <= nb_r + 1'b1;
            pcnt_r <= 3'd1;
            last_r <= 1'b1;
            st_r <= T_FCS;
          end else begin
            o_txd <= f_data[7:0];
            crc_r <= crc_nx;
            nb_r <= nb_r + 1'b1;
            last_r <= f_data[8];
          end
        end
        T_EOS: if (byte_tick) begin
          o_tx_en <= 1'b0;
          o_tx_sym <= emac_pkg::SYM_DATA;
          st_r <= T_DONE;
        end
        T_JAM: if (byte_tick) begin
          pcnt_r <= pcnt_r + 1'b1;
          if (pcnt_r == emac_pkg::JAM_BYTES) begin
            o_tx_en <= 1'b0;
            att_r <= att_r + 1'b1;
            stat_r[emac_pkg::ST_EXC] <= att_r == emac_pkg::MAX_ATTEMPTS - 5'd1;
            retry_r <= att_r != emac_pkg::MAX_ATTEMPTS - 5'd1;
            st_r <= last_r ? T_DONE : T_FLUSH;
          end
        end
        // drop the rest of an ended frame from the fifo
        T_FLUSH: if (f_valid && f_data[8]) begin
          st_r <= T_DONE;
        end
        T_DONE: begin
          o_tx_done <= 1'b1;
          o_tx_status <= {retry_r, stat_r[4:0]};
          o_col_count <= att_r[3:0];
          if (!retry_r) att_r <= '0;
          st_r <= T_IDLE;
        end
      endcase
    end
  end

  // transmit-complete interrupt and sticky underflow, set beats clear
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tx_int <= 1'b0;
      o_under_sticky <= 1'b0;
    end else begin
      o_tx_int <= st_r == T_DONE && i_int_en;
      o_under_sticky <= (st_r == T_DONE && stat_r[emac_pkg::ST_UNDER])
                        || (o_under_sticky && !i_under_clr);
    end
  end

  // -------------------------------------------------
  // receive preamble hunter
  // -------------------------------------------------
  logic [5:0] rcnt_r;
  logic [7:0] rsh_r;
  logic rprev_r, rpv_r;
  logic [5:0] rmin, rones;
  assign rmin = i_snooze ? emac_pkg::RX_MIN_SNOOZE
                : (i_rx_mode == emac_pkg::RXM_10) ? emac_pkg::RX_MIN_10 : emac_pkg::RX_MIN_MII;
  assign rones = (i_rx_mode == emac_pkg::RXM_10) ? emac_pkg::RX_ONES_10 : emac_pkg::RX_ONES_MII;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rs_r <= R_IDLE;
      rcnt_r <= '0;
      rsh_r <= '0;
      rprev_r <= 1'b0;
      rpv_r <= 1'b0;
      o_rx_sfd <= 1'b0;
      o_rx_abort <= 1'b0;
      o_rx_frame <= 1'b0;
    end else begin
      o_rx_sfd <= 1'b0;
      o_rx_abort <= 1'b0;
      unique case (rs_r)
        R_IDLE: if (i_rx_en && i_rx_act) begin
          rs_r <= R_HUNT;
          rcnt_r <= '0;
          rsh_r <= '0;
          rpv_r <= 1'b0;
        end
        R_HUNT: if (!i_rx_act) begin
          rs_r <= R_IDLE;
        end else if (i_rx_bit_en) begin
          rcnt_r <= (rcnt_r == 6'h3F) ? rcnt_r : rcnt_r + 1'b1;
          rsh_r <= {rsh_r[6:0], i_rx_bit};
          rprev_r <= i_rx_bit;
          rpv_r <= i_rx_mode != emac_pkg::RXM_10 || rcnt_r >= emac_pkg::RX_SKIP_10 - 6'd1;
          if (i_rx_mode == emac_pkg::RXM_100 && rcnt_r == '0 && !i_rx_jk) begin
            rs_r <= R_WAIT;
            o_rx_abort <= 1'b1;
          end else if (rpv_r && !rprev_r && !i_rx_bit) begin
            rs_r <= R_WAIT;
            o_rx_abort <= 1'b1;
          end else if (rpv_r && rprev_r && i_rx_bit) begin
            if ({rsh_r[6:0], i_rx_bit} == emac_pkg::RX_SFD_BITS && rcnt_r >= rmin - 6'd1
                && rcnt_r >= rones - 6'd1) begin
              rs_r <= R_FRAME;
              o_rx_sfd <= 1'b1;
              o_rx_frame <= 1'b1;
            end else begin
              rs_r <= R_WAIT;
              o_rx_abort <= 1'b1;
            end
          end
        end
        R_FRAME, R_WAIT: if (!i_rx_act) begin
          rs_r <= R_IDLE;
          o_rx_frame <= 1'b0;
        end
      endcase
    end
  end

  // -------------------------------------------------
  // checks
  // -------------------------------------------------
  gap_before_tx_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_tx_en) |-> $past(gap_r) == emac_pkg::GAP_ALL_BITS && $past(bo_r) == '0)
    else $error("transmit started inside gap or backoff");
  jk_first_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_tx_en) && m100_r |-> o_tx_sym == emac_pkg::SYM_JK)
    else $error("fast frame did not open with start pair");
  sfd_after_pre_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(st_r == T_DATA) |-> o_txd == emac_pkg::SFD_BYTE && $past(pcnt_r) == 3'd7)
    else $error("delimiter not after seven preamble bytes");
  jam_value_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    st_r == T_JAM |-> o_txd == emac_pkg::JAM_BYTE && o_tx_en)
    else $error("jam byte wrong");
  late_no_retry_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_tx_done && o_tx_status[emac_pkg::ST_LATE] |-> !o_tx_status[emac_pkg::ST_RETRY])
    else $error("late collision retried");
  excess_count_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_tx_done && o_tx_status[emac_pkg::ST_EXC] |-> $past(att_r, 2) == 5'd15)
    else $error("excessive collision at wrong attempt");
  gap_restart_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !o_tx_en && i_crs && gap_r < emac_pkg::GAP_PH1_BITS |=> gap_r == '0)
    else $error("carrier did not restart gap");
  rx_zero_abort_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    rs_r == R_HUNT && i_rx_act && i_rx_bit_en && rpv_r && !rprev_r && !i_rx_bit
    && !(i_rx_mode == emac_pkg::RXM_100 && rcnt_r == '0) |=> o_rx_abort && rs_r == R_WAIT)
    else $error("double zero not aborted");
  eos_after_fcs_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    st_r == T_EOS |-> o_tx_sym == emac_pkg::SYM_TR && $past(st_r) inside {T_FCS, T_EOS})
    else $error("end pair misplaced");
endmodule
`default_nettype wire

/* File: rtl/emac_pkg.sv */
/*
 * constants shared by the mac transmit and receive-preamble logic.
 * assumes a 200 mhz system clock and byte-wide transmit data.
 */
package emac_pkg;
  // -------------------------------------------------
  // clock and bit timing
  // -------------------------------------------------
  localparam int CLK_PS = 5000;
  localparam int BIT_PS_10 = 100000;
  localparam int BIT_PS_100 = 10000;
  localparam logic [4:0] BIT_CYC_10 = 5'(BIT_PS_10 / CLK_PS);
  localparam logic [4:0] BIT_CYC_100 = 5'(BIT_PS_100 / CLK_PS);
  // -------------------------------------------------
  // transmit timing in bit times
  // -------------------------------------------------
  localparam logic [6:0] GAP_PH1_BITS = 7'd60;
  localparam logic [6:0] GAP_ALL_BITS = 7'd96;
  localparam int SLOT_SHIFT = 9;
  localparam logic [14:0] JAB_SHORT_BITS = 15'd16000;
  localparam logic [14:0] JAB_LONG_BITS = 15'd26000;
  localparam logic [4:0] MAX_ATTEMPTS = 5'd16;
  localparam logic [4:0] BACKOFF_LIMIT = 5'd10;
  localparam logic [10:0] MIN_BODY_BYTES = 11'd60;
  localparam logic [10:0] LATE_COL_BYTES = 11'd64;
  localparam logic [2:0] PRE_BYTES = 3'd7;
  localparam logic [2:0] JAM_BYTES = 3'd4;
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [7:0] JAM_BYTE = 8'hAA;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
  // -------------------------------------------------
  // line symbol kinds and status bit positions
  // -------------------------------------------------
  localparam logic [1:0] SYM_DATA = 2'h0;
  localparam logic [1:0] SYM_JK = 2'h1;
  localparam logic [1:0] SYM_TR = 2'h2;
  localparam int ST_EXC = 0;
  localparam int ST_LATE = 1;
  localparam int ST_UNDER = 2;
  localparam int ST_JAB = 3;
  localparam int ST_MEM = 4;
  localparam int ST_RETRY = 5;
  // -------------------------------------------------
  // receive preamble figures in bits
  // -------------------------------------------------
  localparam logic [1:0] RXM_MII = 2'h0;
  localparam logic [1:0] RXM_10 = 2'h1;
  localparam logic [1:0] RXM_100 = 2'h2;
  localparam logic [5:0] RX_MIN_MII = 6'd8;
  localparam logic [5:0] RX_MIN_10 = 6'd16;
  localparam logic [5:0] RX_MIN_SNOOZE = 6'd20;
  localparam logic [5:0] RX_ONES_10 = 6'd14;
  localparam logic [5:0] RX_ONES_MII = 6'd6;
  localparam logic [5:0] RX_SKIP_10 = 6'd8;
  localparam logic [7:0] RX_SFD_BITS = 8'b1010_1011;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = 9;
endpackage

/* File: testbench/emac_medium.sv */
/*
 * medium model: carrier, collision and serial receive bits.
 * assumes the bench raises collision requests at falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
module emac_medium (
  input wire logic i_clk,
  input wire logic i_tx_en,
  input wire logic i_col_req,
  output logic o_crs,
  output logic o_col,
  output logic o_bit_en,
  output logic o_bit
);
  // carrier follows our own sending, collision only on request
  assign o_crs = i_tx_en | i_col_req;
  assign o_col = i_tx_en & i_col_req;
  initial begin
    o_bit_en = 1'b0;
    o_bit = 1'b0;
  end
  // bits msb first, strobe every other cycle, inverse between strobes
  task automatic send_bits(input logic [31:0] bits, input int n);
    for (int k = n - 1; k >= 0; k--) begin
      @(negedge i_clk);
      o_bit = bits[k];
      o_bit_en = 1'b1;
      @(negedge i_clk);
      o_bit_en = 1'b0;
      o_bit = ~bits[k];
    end
  endtask
endmodule
`default_nettype wire

/* File: testbench/emac_tx_rx_bench.sv */
/*
 * bench: padded frames, symbol framing, collision jam, preamble hunt.
 * assumes emac_medium beside the design at 100 mb/s.
 */
`timescale 1ns/1ps
`default_nettype none
module emac_tx_rx_bench;
  logic clk = 1'b0, rst_n = 1'b0, sym = 1'b0, valid = 1'b0, last = 1'b0;
  logic col_req = 1'b0, rx_act = 1'b0, pad = 1'b1, int_en = 1'b1, rx_en = 1'b1;
  logic snooze = 1'b0, jk = 1'b0;
  logic [7:0] data = 8'h00, txd, last_b, eb;
  logic [5:0] thr = 6'h3f;
  logic [7:0] sentq[$];
  logic [11:0] note;
  logic [31:0] crc = 32'hffff_ffff;
  logic [1:0] rx_mode = 2'h0, txs, last_s;
  logic ready, tx_en, done, tx_int, under, sfd, abort, frame, crs, col, ben, bitv;
  logic [5:0] status;
  logic [3:0] colc;
  logic [11:0] expq[$];
  logic [31:0] seed = 32'he5bd_7743;
  int bad_count = 0, checked = 0, en_cyc = 0, exp_len = 0, bend = 0;
  always #2.5 clk = ~clk;
  emac_tx_rx emac_tx_rx_i (.i_clk(clk), .i_reset_n(rst_n), .i_speed_100(1'b1),
    .i_sym_mode(sym), .i_tx_valid(valid), .i_tx_data(data), .i_tx_last(last),
    .o_tx_ready(ready), .i_tx_thresh(thr), .i_pad_en(pad), .i_jab_long(1'b0),
    .i_host_err(1'b0), .i_int_en(int_en), .i_under_clr(1'b0), .i_crs(crs), .i_col(col),
    .o_txd(txd), .o_tx_sym(txs), .o_tx_en(tx_en), .o_tx_done(done), .o_tx_status(status),
    .o_col_count(colc), .o_tx_int(tx_int), .o_under_sticky(under), .i_rx_en(rx_en),
    .i_rx_act(rx_act), .i_rx_mode(rx_mode), .i_snooze(snooze), .i_rx_bit_en(ben),
    .i_rx_bit(bitv), .i_rx_jk(jk), .o_rx_sfd(sfd), .o_rx_abort(abort), .o_rx_frame(frame));
  emac_medium emac_medium_i (.i_clk(clk), .i_tx_en(tx_en), .i_col_req(col_req),
    .o_crs(crs), .o_col(col), .o_bit_en(ben), .o_bit(bitv));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // reflected crc-32 over one byte
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    c ^= {24'h00_0000, d};
    for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 32'hedb8_8320) : (c >> 1);
    return c;
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one frame of random bytes into the fifo, waiting on ready
  task automatic send_frame(input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      while (!ready) @(negedge clk);
      seed = xs(seed);
      valid = 1'b1;
      data = seed[7:0];
      sentq.push_back(seed[7:0]);
      last = (k == n - 1);
    end
    @(negedge clk);
    valid = 1'b0;
    last = 1'b0;
  endtask
  task automatic wait_done();
    for (int t = 0; t < 4000 && !done; t++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask
  // results against the oldest note
  always @(posedge clk) begin
    if (done) chk("tx_int", {7'h00, tx_int}, {7'h00, int_en});
    if (done | sfd | abort) begin
      if (expq.size() == 0) chk("extra", 8'h00, 8'hff);
      else begin
        note = expq.pop_front();
        chk("result", {sfd | abort, abort, status & {6{done}}}, note[7:0]);
        if (done) chk("colc", {4'h0, colc}, {4'h0, note[11:8]});
      end
    end
  end
  // line watcher, mid-byte sampling at 16 cycles a byte
  always @(posedge clk) begin
    if (tx_en) begin
      en_cyc <= en_cyc + 1;
      if (en_cyc % 16 == 8) {last_s, last_b} <= {txs, txd};
      if (en_cyc == 8) chk("start", {6'h00, txs}, sym ? 8'h01 : 8'h00);
      if (en_cyc == 8 && !sym) chk("pre", txd, 8'h55);
      if (en_cyc == 120) chk("sfd", txd, 8'hd5);
      // body bytes against what was sent, zero padding after
      if (en_cyc % 16 == 8 && en_cyc > 128 && en_cyc < bend && exp_len != 0) begin
        eb = (sentq.size() != 0) ? sentq.pop_front() : 8'h00;
        chk("body", txd, eb);
        crc = crc_step(crc, eb);
      end
      // check bytes are the inverted crc, low byte first
      if (en_cyc % 16 == 8 && en_cyc > bend && en_cyc < bend + 64 && exp_len != 0) begin
        chk("fcs", txd, ~crc[7:0]);
        crc = crc >> 8;
      end
    end else if (en_cyc != 0) begin
      if (exp_len == 0) chk("jam", last_b, 8'haa);
      else chk("len", 8'(en_cyc / 16), 8'(exp_len));
      if (sym && exp_len != 0) chk("end", {6'h00, last_s}, 8'h02);
      en_cyc <= 0;
      sentq.delete();
      crc = 32'hffff_ffff;
    end
  end
  initial begin
    fork
      begin
        #100000;
        bad_count++;
        tally_and_finish();
      end
    join_none
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    // short padded frame plain, then symbol framed, then unpadded
    for (int m = 0; m < 3; m++) begin
      sym = (m == 1);
      pad = (m != 2);
      int_en = m[0];
      seed = xs(seed);
      thr = 6'(seed[3:0]) + 6'h01;
      exp_len = (m == 2) ? 26 : 72 + m;
      bend = (m == 2) ? 352 : 1088;
      expq.push_back(12'h000);
      send_frame(14);
      wait_done();
    end
    // collision inside the pad: jam then retry status
    pad = 1'b1;
    exp_len = 0;
    expq.push_back(12'h120);
    send_frame(14);
    for (int t = 0; t < 4000 && en_cyc < 400; t++) @(negedge clk);
    col_req = 1'b1;
    wait_done();
    col_req = 1'b0;
    // preamble hunt: good delimiter, then 00 and early 11
    rx_mode = 2'h1;
    snooze = 1'b1;
    rx_act = 1'b1;
    expq.push_back(12'h080);
    emac_medium_i.send_bits(32'haaaa_aaab, 32);
    repeat (3) @(negedge clk);
    chk("frame", {7'h00, frame}, 8'h01);
    rx_act = 1'b0;
    snooze = 1'b0;
    // 00 in mii mode, early 11 after a start pair, missing start pair
    for (int p = 0; p < 3; p++) begin
      repeat (4) @(negedge clk);
      rx_mode = (p == 0) ? 2'h0 : 2'h2;
      jk = (p == 1);
      rx_act = 1'b1;
      expq.push_back(12'h0c0);
      emac_medium_i.send_bits(p ? 32'h0000_000b : 32'h0000_0028, p ? 4 : 6);
      repeat (4) @(negedge clk);
      rx_act = 1'b0;
    end
    repeat (10) @(negedge clk);
    chk("left", 8'(expq.size()), 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
